// ---- logic/rotate_subtract_skip_alu.sv ----
// Summary of operation
// - rotate left to accumulator: bit 7 into bit 0, no flags, memory kept
// - rotate left through carry: old carry to bit 0, bit 7 to carry
// - rotate right: bit 0 into bit 7, to memory or accumulator, no flags
// - rotate right through carry: old carry to bit 7, bit 0 to carry
// - subtract: accumulator minus memory or immediate, to accumulator or memory
// - subtract with borrow also removes the inverse of the carry flag
// - carry clears on negative difference, sets on zero or positive
// - every subtraction updates overflow, zero, aux, carry, signed, carry-zero flags
// - decrement and skip on zero; accumulator variant leaves memory alone
// - increment and skip on zero; accumulator variant leaves memory alone
// - a taken skip costs a dummy cycle; otherwise continue normally
// - byte set writes all ones to memory, no flags
// - bit set forces only the selected bit to one, no flags
// - skip when byte, or selected bit, is nonzero; no flags
// - nibble exchange swaps low and high nibbles, no flags
//
// Added by the designer: the Wishbone slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module rotate_subtract_skip_alu
  import skip_alu_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic execValid,
  input wire exec_req_s execReq,
  output logic execReady,
  output logic memWrite,
  output logic [7:0] memWriteData,
  output logic skipNext,
  output logic [7:0] accumulator,
  output alu_flags_s statusFlags,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  typedef enum logic {
    ST_RUN,
    ST_DUMMY
  } exec_state_e;

  // register bus targets, decoded once and shared by write and read paths
  typedef enum logic [1:0] {
    SEL_ACCUM,
    SEL_FLAGS,
    SEL_STATE,
    SEL_NONE
  } reg_sel_e;

  // every flip-flop of the block lives in this one record
  typedef struct packed {
    exec_state_e fsm;
    logic [7:0] acc;
    alu_flags_s flags;
    logic memWr;
    logic [7:0] memData;
    logic skip;
    logic lastSkip;
    logic [7:0] lastResult;
    logic ack;
    logic [31:0] rdData;
  } alu_state_s;

  localparam alu_state_s STATE_RESET = '{
    fsm: ST_RUN,
    acc: ACCUM_RESET,
    flags: FLAGS_RESET,
    memWr: 1'b0,
    memData: 8'h00,
    skip: 1'b0,
    lastSkip: 1'b0,
    lastResult: 8'h00,
    ack: 1'b0,
    rdData: 32'h0000_0000
  };

  alu_state_s cur;
  alu_state_s next_cur;

  // rotate helpers shared by the plain and through-carry forms
  function automatic logic [7:0] rotLeft(input logic [7:0] v, input logic fill);
    rotLeft = {v[6:0], fill};
  endfunction

  function automatic logic [7:0] rotRight(input logic [7:0] v, input logic fill);
    rotRight = {fill, v[7:1]};
  endfunction

  // one-hot mask for the selected bit
  function automatic logic [7:0] bitMask(input logic [2:0] sel);
    bitMask = 8'h01 << sel;
  endfunction

  // pack the flag record into a status word
  function automatic logic [31:0] flagsWord(input alu_flags_s f);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[FLAG_CARRY_POS] = f.carry;
    w[FLAG_AUX_POS] = f.aux_carry_flag;
    w[FLAG_ZERO_POS] = f.zero;
    w[FLAG_OVERFLOW_POS] = f.overflow_flag;
    w[FLAG_SIGNED_POS] = f.signed_compare_flag;
    w[FLAG_CARRY_ZERO_POS] = f.carry_zero_flag;
    flagsWord = w;
  endfunction

  function automatic alu_flags_s wordFlags(input logic [31:0] w);
    alu_flags_s f;
    f.carry = w[FLAG_CARRY_POS];
    f.aux_carry_flag = w[FLAG_AUX_POS];
    f.zero = w[FLAG_ZERO_POS];
    f.overflow_flag = w[FLAG_OVERFLOW_POS];
    f.signed_compare_flag = w[FLAG_SIGNED_POS];
    f.carry_zero_flag = w[FLAG_CARRY_ZERO_POS];
    wordFlags = f;
  endfunction

  // one address decoder so a write and a read of one offset cannot disagree
  function automatic reg_sel_e decodeAdr(input logic [3:0] adr);
    if (adr == REG_ACCUM_OFFSET) begin
      decodeAdr = SEL_ACCUM;
    end else if (adr == REG_FLAGS_OFFSET) begin
      decodeAdr = SEL_FLAGS;
    end else if (adr == REG_STATE_OFFSET) begin
      decodeAdr = SEL_STATE;
    end else begin
      decodeAdr = SEL_NONE;
    end
  endfunction

  // pack the read-only state register; bits outside the fields read zero
  function automatic logic [31:0] stateWord(input logic busy, input logic skipped,
    input logic [7:0] result);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[STATE_BUSY_POS] = busy;
    w[STATE_SKIP_POS] = skipped;
    w[STATE_RESULT_LSB +: 8] = result;
    stateWord = w;
  endfunction

  // subtraction datapath inputs
  logic [7:0] subOperand;
  logic subBorrow;
  logic subChain;
  logic [7:0] subResult;
  alu_flags_s subFlags;
  logic take;
  logic busReq;
  logic busWrite;
  reg_sel_e regSel;

  // a request is only accepted outside the dummy slot
  assign execReady = (cur.fsm == ST_RUN);
  assign take = execValid & execReady;

  // immediate only feeds the accumulator-destination subtract
  always_comb begin
    subOperand = (execReq.useImm && !execReq.toMem) ? execReq.immData : execReq.memByte;
    subChain = (execReq.op == OP_SUBTRACT_BORROW);
    // borrow is the inverse of carry for both destinations
    subBorrow = subChain ? ~cur.flags.carry : 1'b0;
  end

  borrow_subtractor subUnit (
    .minuend(cur.acc),
    .subtrahend(subOperand),
    .borrowIn(subBorrow),
    .chainZero(subChain),
    .oldCarryZero(cur.flags.carry_zero_flag),
    .difference(subResult),
    .flags(subFlags)
  );

  // bus handshake: ack one cycle after the strobe, dropped the cycle after
  assign busReq = wb_cyc_i & wb_stb_i & ~cur.ack;
  assign busWrite = busReq & wb_we_i & wb_sel_i[0];
  // unmapped offsets decode to none: ack given, write dropped, read zero
  assign regSel = decodeAdr(wb_adr_i);

  // next-state logic for execution, skip slot and register bus
  always_comb begin
    logic [7:0] res;
    logic [7:0] mask;
    res = 8'h00;
    mask = bitMask(execReq.bitSel);
    next_cur = cur;
    next_cur.memWr = 1'b0;
    next_cur.skip = 1'b0;
    next_cur.ack = busReq;

    // software writes land first so an instruction in the same cycle wins
    if (busWrite) begin
      if (regSel == SEL_ACCUM) begin
        next_cur.acc = wb_dat_i[7:0];
      end else if (regSel == SEL_FLAGS) begin
        next_cur.flags = wordFlags(wb_dat_i);
      end
    end

    // read data captured at the request so it is steady with ack
    if (busReq) begin
      if (regSel == SEL_ACCUM) begin
        next_cur.rdData = {24'h000000, cur.acc};
      end else if (regSel == SEL_FLAGS) begin
        next_cur.rdData = flagsWord(cur.flags);
      end else if (regSel == SEL_STATE) begin
        next_cur.rdData = stateWord(cur.fsm == ST_DUMMY, cur.lastSkip, cur.lastResult);
      end else begin
        next_cur.rdData = 32'h0000_0000; // unmapped reads return zero
      end
    end

    case (cur.fsm)
      ST_RUN: begin
        if (take) begin
          case (execReq.op)
            OP_ROT_LEFT: begin
              res = rotLeft(execReq.memByte, execReq.memByte[7]);
              next_cur.memWr = execReq.toMem;
              if (!execReq.toMem) begin
                next_cur.acc = res;
              end
            end
            OP_ROT_LEFT_TO_ACC: begin
              res = rotLeft(execReq.memByte, execReq.memByte[7]);
              next_cur.acc = res;
            end
            OP_ROT_LEFT_CARRY: begin
              res = rotLeft(execReq.memByte, cur.flags.carry);
              next_cur.flags.carry = execReq.memByte[7];
              next_cur.memWr = execReq.toMem;
              if (!execReq.toMem) begin
                next_cur.acc = res;
              end
            end
            OP_ROT_RIGHT: begin
              res = rotRight(execReq.memByte, execReq.memByte[0]);
              next_cur.memWr = execReq.toMem;
              if (!execReq.toMem) begin
                next_cur.acc = res;
              end
            end
            OP_ROT_RIGHT_CARRY: begin
              res = rotRight(execReq.memByte, cur.flags.carry);
              next_cur.flags.carry = execReq.memByte[0];
              next_cur.memWr = execReq.toMem;
              if (!execReq.toMem) begin
                next_cur.acc = res;
              end
            end
            OP_SUBTRACT, OP_SUBTRACT_BORROW: begin
              res = subResult;
              next_cur.flags = subFlags;
              next_cur.memWr = execReq.toMem;
              if (!execReq.toMem) begin
                next_cur.acc = res;
              end
            end
            OP_DEC_SKIP_ZERO: begin
              res = execReq.memByte - 8'h01;
              next_cur.memWr = execReq.toMem;
              if (!execReq.toMem) begin
                next_cur.acc = res;
              end
              next_cur.skip = (res == 8'h00);
            end
            OP_INC_SKIP_ZERO: begin
              res = execReq.memByte + 8'h01;
              next_cur.memWr = execReq.toMem;
              if (!execReq.toMem) begin
                next_cur.acc = res;
              end
              next_cur.skip = (res == 8'h00);
            end
            OP_SKIP_NONZERO: begin
              res = execReq.memByte;
              next_cur.skip = (execReq.memByte != 8'h00);
            end
            OP_SKIP_NONZERO_BIT: begin
              res = execReq.memByte;
              next_cur.skip = ((execReq.memByte & mask) != 8'h00);
            end
            OP_SET_BYTE: begin
              res = ALL_ONES_BYTE;
              next_cur.memWr = 1'b1;
            end
            OP_SET_BIT: begin
              res = execReq.memByte | mask;
              next_cur.memWr = 1'b1;
            end
            OP_NIBBLE_EXCHANGE: begin
              res = {execReq.memByte[3:0], execReq.memByte[7:4]};
              next_cur.memWr = execReq.toMem;
              if (!execReq.toMem) begin
                next_cur.acc = res;
              end
            end
            default: begin
              res = cur.lastResult; // no-op keeps accumulator, flags and result; clears the recorded skip
            end
          endcase
          next_cur.memData = res;
          next_cur.lastResult = res;
          next_cur.lastSkip = next_cur.skip;
          // a taken skip blocks the next request for the dummy slot
          if (next_cur.skip) begin
            next_cur.fsm = ST_DUMMY;
          end
        end
      end
      ST_DUMMY: begin
        // no request is accepted here while execReady is low; nothing executes
        next_cur.fsm = ST_RUN;
      end
      default: begin
        next_cur.fsm = ST_RUN;
      end
    endcase
  end

  // the whole state record is registered in one place
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cur <= STATE_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  // outputs straight from flip-flops
  assign memWrite = cur.memWr;
  assign memWriteData = cur.memData;
  assign skipNext = cur.skip;
  assign accumulator = cur.acc;
  assign statusFlags = cur.flags;
  assign wb_ack_o = cur.ack;
  assign wb_dat_o = cur.rdData;

endmodule
`default_nettype wire

// ---- logic/skip_alu_pkg.sv ----
package skip_alu_pkg;

  // operation codes presented on the execute port
  typedef enum logic [4:0] {
    OP_NOP,
    OP_ROT_LEFT,
    OP_ROT_LEFT_TO_ACC,
    OP_ROT_LEFT_CARRY,
    OP_ROT_RIGHT,
    OP_ROT_RIGHT_CARRY,
    OP_SUBTRACT,
    OP_SUBTRACT_BORROW,
    OP_DEC_SKIP_ZERO,
    OP_INC_SKIP_ZERO,
    OP_SKIP_NONZERO,
    OP_SKIP_NONZERO_BIT,
    OP_SET_BYTE,
    OP_SET_BIT,
    OP_NIBBLE_EXCHANGE
  } alu_op_e;

  // one instruction as handed over by the decoder
  typedef struct packed {
    alu_op_e op;
    logic [7:0] memByte;
    logic [7:0] immData;
    logic [2:0] bitSel;
    logic useImm;
    logic toMem;
  } exec_req_s;

  // status flags kept by the block
  typedef struct packed {
    logic carry_zero_flag;
    logic signed_compare_flag;
    logic overflow_flag;
    logic zero;
    logic aux_carry_flag;
    logic carry;
  } alu_flags_s;

  // flag positions inside the status register
  localparam int FLAG_CARRY_POS = 0;
  localparam int FLAG_AUX_POS = 1;
  localparam int FLAG_ZERO_POS = 2;
  localparam int FLAG_OVERFLOW_POS = 3;
  localparam int FLAG_SIGNED_POS = 4;
  localparam int FLAG_CARRY_ZERO_POS = 5;
  localparam int FLAG_COUNT = 6;

  // register byte offsets on the wishbone slave
  localparam logic [3:0] REG_ACCUM_OFFSET = 4'h0;
  localparam logic [3:0] REG_FLAGS_OFFSET = 4'h4;
  localparam logic [3:0] REG_STATE_OFFSET = 4'h8;

  // state register field positions
  localparam int STATE_BUSY_POS = 0;
  localparam int STATE_SKIP_POS = 1;
  localparam int STATE_RESULT_LSB = 8;

  // values after reset, and the byte written by byte set
  localparam logic [7:0] ACCUM_RESET = 8'h00;
  localparam alu_flags_s FLAGS_RESET = '0;
  localparam logic [7:0] ALL_ONES_BYTE = 8'hFF;

  // cycles of the inserted dummy slot after a taken skip
  localparam int SKIP_DUMMY_CYCLES = 1;

endpackage

// ---- logic/borrow_subtractor.sv ----
`timescale 1ns/100ps
`default_nettype none
// eight-bit subtractor with the full set of arithmetic status flags
module borrow_subtractor
  import skip_alu_pkg::*;
(
  input wire logic [7:0] minuend,
  input wire logic [7:0] subtrahend,
  input wire logic borrowIn,
  input wire logic chainZero,
  input wire logic oldCarryZero,
  output logic [7:0] difference,
  output alu_flags_s flags
);

  logic [8:0] wide;
  logic [4:0] lowWide;
  logic ovf;

  // ninth bit is the borrow out; carry is its inverse, so negative clears it
  always_comb begin
    wide = {1'b0, minuend} - {1'b0, subtrahend} - {8'h00, borrowIn};
    lowWide = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]} - {4'h0, borrowIn};
    difference = wide[7:0];
    ovf = (minuend[7] ^ subtrahend[7]) & (minuend[7] ^ wide[7]);
    flags.carry = ~wide[8];
    flags.aux_carry_flag = ~lowWide[4];
    flags.zero = (wide[7:0] == 8'h00);
    flags.overflow_flag = ovf;
    flags.signed_compare_flag = ovf ^ wide[7];
    // chained form keeps zero only while every byte so far was zero
    flags.carry_zero_flag = chainZero ? ((wide[7:0] == 8'h00) & oldCarryZero)
                                      : (wide[7:0] == 8'h00);
  end

endmodule
`default_nettype wire

// ---- bench/rotate_subtract_skip_alu_checker.sv ----
`timescale 1ns/100ps
`default_nettype none
module rotate_subtract_skip_alu_checker
  import skip_alu_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic execValid,
  input wire exec_req_s execReq,
  input wire logic execReady,
  input wire logic memWrite,
  input wire logic [7:0] memWriteData,
  input wire logic skipNext,
  input wire logic [7:0] accumulator,
  input wire alu_flags_s statusFlags,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // immediate only exists for the accumulator form, so memory form takes the byte
  wire logic [7:0] opnd = (execReq.useImm && !execReq.toMem) ? execReq.immData : execReq.memByte;
  wire logic taken = execValid && execReady;
  wire logic [7:0] mb = execReq.memByte;
  wire alu_op_e op = execReq.op;
  // a taken skip leaves exactly one cycle with no instruction accepted
  sequence dummySlot;
    !execReady ##1 execReady;
  endsequence
  chk_rotl_acc: assert property (taken && op == OP_ROT_LEFT_TO_ACC |=>
    accumulator == {$past(mb[6:0]), $past(mb[7])} && !memWrite && $stable(statusFlags))
    else $error("rotate left to accumulator wrong");
  chk_sub_carry: assert property (taken && op == OP_SUBTRACT |=>
    statusFlags.carry == ($past(accumulator) >= $past(opnd))) else $error("subtract carry wrong");
  chk_sub_zero: assert property (taken && op == OP_SUBTRACT |=>
    statusFlags.zero == ($past(accumulator) == $past(opnd))) else $error("subtract zero wrong");
  chk_dec_skip: assert property (taken && op == OP_DEC_SKIP_ZERO |=>
    skipNext == ($past(mb) == 8'h01)) else $error("decrement skip wrong");
  chk_inc_skip: assert property (taken && op == OP_INC_SKIP_ZERO |=>
    skipNext == ($past(mb) == 8'hFF)) else $error("increment skip wrong");
  chk_skip_dummy: assert property (skipNext |-> dummySlot)
    else $error("dummy cycle wrong");
  chk_set_byte: assert property (taken && op == OP_SET_BYTE |=>
    memWrite && memWriteData == 8'hFF) else $error("byte set wrong");
  chk_nibble_swap: assert property (taken && op == OP_NIBBLE_EXCHANGE |=>
    memWriteData == {$past(mb[3:0]), $past(mb[7:4])}) else $error("nibble exchange wrong");
  chk_ack_pulse: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus acknowledge wrong");
endmodule
`default_nettype wire

// ---- bench/rotate_subtract_skip_alu_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
module rotate_subtract_skip_alu_bench
  import skip_alu_pkg::*;
;
  logic ref_clk = 0, rst = 1, execValid = 0, wbCyc = 0, wbStb = 0, wbWe = 0;
  logic execReady, memWrite, skipNext, wbAck;
  logic [3:0] wbAdr = 0;
  logic [3:0] wbSel = 4'hF;
  logic [7:0] memWriteData, accumulator;
  logic [31:0] wbDatI = 0, wbDatO, rd;
  exec_req_s execReq = '0;
  alu_flags_s statusFlags;
  int miscompares = 0, checks_done = 0, cycles = 0;
  rotate_subtract_skip_alu i_dut (.ref_clk(ref_clk), .rst(rst), .execValid(execValid),
    .execReq(execReq), .execReady(execReady), .memWrite(memWrite),
    .memWriteData(memWriteData), .skipNext(skipNext), .accumulator(accumulator),
    .statusFlags(statusFlags), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck));
  initial forever #4 ref_clk = ~ref_clk;
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // request held until ack is seen at an edge, then released at that edge
  task automatic wb(input logic we, input logic [3:0] adr, input logic [7:0] d);
    @(posedge ref_clk);
    wbCyc <= 1'h1;
    wbStb <= 1'h1;
    wbWe <= we;
    wbAdr <= adr;
    wbDatI <= {24'h0, d};
    @(posedge ref_clk iff wbAck);
    rd = wbDatO;
    wbCyc <= 1'h0;
    wbStb <= 1'h0;
  endtask
  // x feeds both immediate and bit select; it is {useImm, toMem}
  task automatic ex(input alu_op_e op, input logic [7:0] m, input logic [7:0] x,
    input logic [1:0] it);
    @(posedge ref_clk);
    execValid <= 1'h1;
    execReq <= '{op, m, x, x[2:0], it[1], it[0]};
    @(posedge ref_clk iff execReady);
    execValid <= 1'h0;
    #1;
  endtask
  task automatic res(input logic mw, input logic [7:0] d, input logic [7:0] a,
    input logic [5:0] f, input logic sk);
    chk(memWrite, mw);
    if (mw) chk(memWriteData, d);
    chk(accumulator, a);
    chk(statusFlags, f);
    chk(skipNext, sk);
    chk(execReady, !sk);
  endtask
  // hang guard: the whole sequence needs under a hundred cycles
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      miscompares++;
      wrap_up();
    end
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'h0;
    #1;
    res(0, 0, 8'h00, 6'h00, 0);
    wb(1, REG_ACCUM_OFFSET, 8'h5A);
    wb(0, REG_ACCUM_OFFSET, 0);
    chk(rd, 32'h5A);
    wb(0, 4'hC, 0);
    chk(rd, 32'h0);
    ex(OP_ROT_LEFT_TO_ACC, 8'h81, 0, 2'h0);
    res(0, 0, 8'h03, 6'h00, 0);
    ex(OP_ROT_LEFT_TO_ACC, 8'h81, 0, 2'h1);
    res(0, 0, 8'h03, 6'h00, 0);
    // plain rotate left back to memory leaves the accumulator alone
    ex(OP_ROT_LEFT, 8'h81, 0, 2'h1);
    res(1, 8'h03, 8'h03, 6'h00, 0);
    ex(OP_ROT_LEFT_CARRY, 8'h80, 0, 2'h1);
    res(1, 8'h00, 8'h03, 6'h01, 0);
    ex(OP_ROT_LEFT_CARRY, 8'h01, 0, 2'h0);
    res(0, 0, 8'h03, 6'h00, 0);
    ex(OP_ROT_RIGHT, 8'h01, 0, 2'h1);
    res(1, 8'h80, 8'h03, 6'h00, 0);
    ex(OP_ROT_RIGHT, 8'h02, 0, 2'h0);
    res(0, 0, 8'h01, 6'h00, 0);
    ex(OP_ROT_RIGHT_CARRY, 8'h01, 0, 2'h1);
    res(1, 8'h00, 8'h01, 6'h01, 0);
    ex(OP_ROT_RIGHT_CARRY, 8'h00, 0, 2'h0);
    res(0, 0, 8'h80, 6'h00, 0);
    wb(1, REG_ACCUM_OFFSET, 8'h10);
    ex(OP_SUBTRACT, 8'h20, 0, 2'h0);
    res(0, 0, 8'hF0, 6'h12, 0);
    ex(OP_SUBTRACT, 8'h55, 8'hF0, 2'h2);
    res(0, 0, 8'h00, 6'h27, 0);
    ex(OP_SUBTRACT, 8'h01, 0, 2'h1);
    res(1, 8'hFF, 8'h00, 6'h10, 0);
    wb(1, REG_ACCUM_OFFSET, 8'h80);
    ex(OP_SUBTRACT_BORROW, 8'h00, 0, 2'h0);
    res(0, 0, 8'h7F, 6'h19, 0);
    ex(OP_SUBTRACT_BORROW, 8'h7F, 0, 2'h1);
    res(1, 8'h00, 8'h7F, 6'h07, 0);
    ex(OP_DEC_SKIP_ZERO, 8'h01, 0, 2'h1);
    res(1, 8'h00, 8'h7F, 6'h07, 1);
    ex(OP_DEC_SKIP_ZERO, 8'h05, 0, 2'h0);
    res(0, 0, 8'h04, 6'h07, 0);
    ex(OP_INC_SKIP_ZERO, 8'hFF, 0, 2'h0);
    res(0, 0, 8'h00, 6'h07, 1);
    ex(OP_INC_SKIP_ZERO, 8'h10, 0, 2'h1);
    res(1, 8'h11, 8'h00, 6'h07, 0);
    ex(OP_SET_BYTE, 8'h12, 0, 2'h1);
    res(1, 8'hFF, 8'h00, 6'h07, 0);
    ex(OP_SET_BIT, 8'h81, 8'h05, 2'h1);
    res(1, 8'hA1, 8'h00, 6'h07, 0);
    ex(OP_SKIP_NONZERO, 8'h00, 0, 2'h0);
    res(0, 0, 8'h00, 6'h07, 0);
    ex(OP_SKIP_NONZERO, 8'h40, 0, 2'h0);
    res(0, 0, 8'h00, 6'h07, 1);
    ex(OP_SKIP_NONZERO_BIT, 8'hFE, 8'h00, 2'h0);
    res(0, 0, 8'h00, 6'h07, 0);
    ex(OP_SKIP_NONZERO_BIT, 8'h80, 8'h07, 2'h0);
    res(0, 0, 8'h00, 6'h07, 1);
    wb(0, REG_STATE_OFFSET, 0);
    chk(rd, 32'h0000_8002);
    ex(OP_NIBBLE_EXCHANGE, 8'h3C, 0, 2'h1);
    res(1, 8'hC3, 8'h00, 6'h07, 0);
    wb(0, REG_STATE_OFFSET, 0);
    chk(rd, 32'h0000_C300);
    // a write with the low byte lane off must be dropped
    wbSel <= 4'hE;
    wb(1, REG_ACCUM_OFFSET, 8'h77);
    wbSel <= 4'hF;
    wb(0, REG_ACCUM_OFFSET, 0);
    chk(rd, 32'h0);
    wb(0, REG_FLAGS_OFFSET, 0);
    chk(rd, 32'h07);
    wrap_up();
  end
endmodule
bind rotate_subtract_skip_alu rotate_subtract_skip_alu_checker i_chk (.ref_clk(ref_clk),
  .rst(rst), .execValid(execValid), .execReq(execReq), .execReady(execReady),
  .memWrite(memWrite), .memWriteData(memWriteData), .skipNext(skipNext),
  .accumulator(accumulator), .statusFlags(statusFlags), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));
`default_nettype wire
